// ---- logic/cbf_pkg.sv ----
/*
  cbf_pkg: offsets, field positions, reset values, supply codes and the
  packed carriers shared by the socket force/control register block.
  assumes: one socket, register offsets given relative to its base.
*/
package cbf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FORCE = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [31:0] RST_FORCE = 32'h0000_0000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // force-event field positions
  // ----------------------------------------------------------------
  localparam int FB_RETEST = 14;
  localparam int FB_YY = 13;
  localparam int FB_XX = 12;
  localparam int FB_THREE = 11;
  localparam int FB_FIVE = 10;
  localparam int FB_INVALID = 9;
  localparam int FB_LOST = 8;
  localparam int FB_UNREC = 7;
  localparam int FB_CARDBUS = 5;
  localparam int FB_SIXTEEN = 4;
  localparam int FB_PWR_EVT = 3;
  localparam int FB_DET2_EVT = 2;
  localparam int FB_DET1_EVT = 1;
  localparam int FB_STS_EVT = 0;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CB_STOP_POLICY = 7;
  localparam int CB_VCC_HI = 6;
  localparam int CB_VCC_LO = 4;
  localparam int CB_VPP_HI = 2;
  localparam int CB_VPP_LO = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hf7;

  // ----------------------------------------------------------------
  // supply request codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SUP_OFF = 3'h0;
  localparam logic [2:0] VPP_12V = 3'h1;
  localparam logic [2:0] SUP_5V = 3'h2;
  localparam logic [2:0] SUP_3V = 3'h3;
  localparam logic [2:0] SUP_XX = 3'h4;
  localparam logic [2:0] SUP_YY = 3'h5;

  // fixed socket capability: 3 V and 5 V only
  localparam logic SOCK_YY_CAP = 1'b0;
  localparam logic SOCK_XX_CAP = 1'b0;
  localparam logic SOCK_THREE_CAP = 1'b1;
  localparam logic SOCK_FIVE_CAP = 1'b1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic yy;
    logic xx;
    logic three;
    logic five;
  } cbf_volt_t;

  typedef struct packed {
    cbf_volt_t volt;
    logic invalid_req;
    logic lost_data;
    logic unrec_card;
    logic cardbus;
    logic sixteen;
  } cbf_state_force_t;

  typedef struct packed {
    logic power_change;
    logic detect_two;
    logic detect_one;
    logic status_change;
  } cbf_event_force_t;

endpackage

// ---- logic/cbf_supply_check.sv ----
/*
  cbf_supply_check: judges the requested vcc code against what the socket
  can give and what the card accepts; vpp only needs a known code and vcc on.
  assumes: card support flags are already settled; purely combinational.
*/
module cbf_supply_check (
  input wire logic [2:0] vcc_i,
  input wire logic [2:0] vpp_i,
  input wire cbf_pkg::cbf_volt_t card_i,
  output logic vcc_ok_o,
  output logic vpp_ok_o
);

  // ----------------------------------------------------------------
  // vcc: socket must supply it and the card must accept it
  // ----------------------------------------------------------------
  always_comb begin
    case (vcc_i)
      cbf_pkg::SUP_OFF: vcc_ok_o = 1'b1;
      cbf_pkg::SUP_5V: vcc_ok_o = cbf_pkg::SOCK_FIVE_CAP & card_i.five;
      cbf_pkg::SUP_3V: vcc_ok_o = cbf_pkg::SOCK_THREE_CAP & card_i.three;
      cbf_pkg::SUP_XX: vcc_ok_o = cbf_pkg::SOCK_XX_CAP & card_i.xx;
      cbf_pkg::SUP_YY: vcc_ok_o = cbf_pkg::SOCK_YY_CAP & card_i.yy;
      default: vcc_ok_o = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // vpp: reserved codes refused; any vpp needs vcc on
  // ----------------------------------------------------------------
  always_comb begin
    case (vpp_i)
      cbf_pkg::SUP_OFF: vpp_ok_o = 1'b1;
      cbf_pkg::VPP_12V,
      cbf_pkg::SUP_5V,
      cbf_pkg::SUP_3V,
      cbf_pkg::SUP_XX,
      cbf_pkg::SUP_YY: vpp_ok_o = (vcc_i != cbf_pkg::SUP_OFF);
      default: vpp_ok_o = 1'b0;
    endcase
  end

endmodule

// ---- logic/cbf_socket_regs.sv ----
/*
  cbf_socket_regs: socket force-event and socket control registers,
  with supply gating, power-control enable and card-clock stop policy.
  assumes: host register access is a single-cycle memory strobe on the
  PCI clock; interrogation sequencer, event/present-state registers and
  power switch live outside and follow the strobes driven here.
*/
module cbf_socket_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] wdata_i,
  input wire logic interrog_done_i,
  input wire cbf_pkg::cbf_volt_t interrog_volt_i,
  input wire logic socket_idle_i,
  input wire logic pci_clk_stop_prep_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic interrogate_o,
  output logic state_force_wr_o,
  output cbf_pkg::cbf_state_force_t state_force_o,
  output logic event_force_wr_o,
  output cbf_pkg::cbf_event_force_t event_force_o,
  output logic power_ctl_en_o,
  output logic [2:0] vcc_apply_o,
  output logic [2:0] vpp_apply_o,
  output logic card_clk_stop_ok_o,
  output logic invalid_power_req_o,
  output logic [2:0] socket_cap_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic force_wr;
  logic ctrl_wr;
  logic force_any_volt;

  assign force_wr = wr_i & (addr_i == cbf_pkg::OFS_FORCE);
  assign ctrl_wr = wr_i & (addr_i == cbf_pkg::OFS_CTRL);
  assign force_any_volt = |wdata_i[cbf_pkg::FB_YY:cbf_pkg::FB_FIVE];

  // ----------------------------------------------------------------
  // control register and card support copy
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  cbf_pkg::cbf_volt_t card_volt_r;
  cbf_pkg::cbf_volt_t card_volt_nxt;
  logic pwr_en_r;
  logic pwr_en_nxt;
  logic invalid_r;
  logic invalid_nxt;
  logic ctrl_upd_r;
  logic ctrl_upd_nxt;
  logic vcc_ok;
  logic vpp_ok;
  logic [2:0] vcc_req;
  logic [2:0] vpp_req;

  assign vcc_req = ctrl_r[cbf_pkg::CB_VCC_HI:cbf_pkg::CB_VCC_LO];
  assign vpp_req = ctrl_r[cbf_pkg::CB_VPP_HI:cbf_pkg::CB_VPP_LO];

  cbf_supply_check u_check (
    .vcc_i(vcc_req),
    .vpp_i(vpp_req),
    .card_i(card_volt_r),
    .vcc_ok_o(vcc_ok),
    .vpp_ok_o(vpp_ok)
  );

  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_upd_nxt = ctrl_wr;
    if (ctrl_wr) begin
      ctrl_nxt = wdata_i[7:0] & cbf_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= cbf_pkg::RST_CTRL;
      ctrl_upd_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ctrl_upd_r <= ctrl_upd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // card support copy
  // ----------------------------------------------------------------
  always_comb begin
    card_volt_nxt = card_volt_r;
    if (interrog_done_i) begin
      card_volt_nxt = interrog_volt_i;
    end
    // a force in the same cycle wins: the host asked for it last
    if (force_wr) begin
      card_volt_nxt = wdata_i[cbf_pkg::FB_YY:cbf_pkg::FB_FIVE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_volt_r <= '0;
    end else begin
      card_volt_r <= card_volt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // socket power control enable
  // ----------------------------------------------------------------
  always_comb begin
    pwr_en_nxt = pwr_en_r;
    // a forced voltage keeps power off until a fresh interrogation
    if (force_wr && force_any_volt) begin
      pwr_en_nxt = 1'b0;
    end
    // retest re-enables after the fresh result is in
    if (interrog_done_i) begin
      pwr_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_en_r <= 1'b1;
    end else begin
      pwr_en_r <= pwr_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // invalid power request flag
  // ----------------------------------------------------------------
  always_comb begin
    invalid_nxt = invalid_r;
    // judged on the settled setting the cycle after a write, so a valid
    // write after a bad one clears it; a forced value wins that cycle
    if (!vcc_ok || !vpp_ok) begin
      invalid_nxt = 1'b1;
    end else if (ctrl_upd_r) begin
      invalid_nxt = 1'b0;
    end
    if (force_wr) begin
      invalid_nxt = wdata_i[cbf_pkg::FB_INVALID];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      invalid_r <= 1'b0;
    end else begin
      invalid_r <= invalid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // strobes toward present-state, event register and sequencer
  // ----------------------------------------------------------------
  logic interrogate_nxt;
  logic state_wr_nxt;
  logic event_wr_nxt;
  cbf_pkg::cbf_state_force_t state_force_nxt;
  cbf_pkg::cbf_event_force_t event_force_nxt;

  always_comb begin
    // zeros written to retest start nothing
    interrogate_nxt = force_wr & wdata_i[cbf_pkg::FB_RETEST];
    state_wr_nxt = force_wr;
    event_wr_nxt = force_wr;
    state_force_nxt = state_force_o;
    event_force_nxt = event_force_o;
    if (force_wr) begin
      state_force_nxt.volt = wdata_i[cbf_pkg::FB_YY:cbf_pkg::FB_FIVE];
      state_force_nxt.invalid_req = wdata_i[cbf_pkg::FB_INVALID];
      state_force_nxt.lost_data = wdata_i[cbf_pkg::FB_LOST];
      state_force_nxt.unrec_card = wdata_i[cbf_pkg::FB_UNREC];
      state_force_nxt.cardbus = wdata_i[cbf_pkg::FB_CARDBUS];
      state_force_nxt.sixteen = wdata_i[cbf_pkg::FB_SIXTEEN];
      // levels for powered, detect and status stay with their pins
      event_force_nxt.power_change = wdata_i[cbf_pkg::FB_PWR_EVT];
      event_force_nxt.detect_two = wdata_i[cbf_pkg::FB_DET2_EVT];
      event_force_nxt.detect_one = wdata_i[cbf_pkg::FB_DET1_EVT];
      event_force_nxt.status_change = wdata_i[cbf_pkg::FB_STS_EVT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrogate_o <= 1'b0;
      state_force_wr_o <= 1'b0;
      event_force_wr_o <= 1'b0;
      state_force_o <= '0;
      event_force_o <= '0;
    end else begin
      interrogate_o <= interrogate_nxt;
      state_force_wr_o <= state_wr_nxt;
      event_force_wr_o <= event_wr_nxt;
      state_force_o <= state_force_nxt;
      event_force_o <= event_force_nxt;
    end
  end

  // ----------------------------------------------------------------
  // supply, clock policy and flag outputs
  // ----------------------------------------------------------------
  logic [2:0] vcc_apply_nxt;
  logic [2:0] vpp_apply_nxt;
  logic clk_stop_nxt;

  always_comb begin
    // refused requests fall back to off rather than a guessed level
    vcc_apply_nxt = cbf_pkg::SUP_OFF;
    vpp_apply_nxt = cbf_pkg::SUP_OFF;
    if (pwr_en_r && vcc_ok && vpp_ok) begin
      vcc_apply_nxt = vcc_req;
      vpp_apply_nxt = vpp_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vcc_apply_o <= cbf_pkg::SUP_OFF;
      vpp_apply_o <= cbf_pkg::SUP_OFF;
      power_ctl_en_o <= 1'b0;
      invalid_power_req_o <= 1'b0;
      socket_cap_o <= '0;
    end else begin
      vcc_apply_o <= vcc_apply_nxt;
      vpp_apply_o <= vpp_apply_nxt;
      power_ctl_en_o <= pwr_en_r;
      invalid_power_req_o <= invalid_r;
      // order: yy/xx packed as one zero bit, then three, five
      socket_cap_o <= {cbf_pkg::SOCK_YY_CAP | cbf_pkg::SOCK_XX_CAP,
                       cbf_pkg::SOCK_THREE_CAP, cbf_pkg::SOCK_FIVE_CAP};
    end
  end

  // ----------------------------------------------------------------
  // card clock stop policy
  // ----------------------------------------------------------------
  always_comb begin
    // same-clock levels, so no synchroniser; one cycle late is harmless
    if (ctrl_r[cbf_pkg::CB_STOP_POLICY]) begin
      clk_stop_nxt = socket_idle_i;
    end else begin
      clk_stop_nxt = socket_idle_i & pci_clk_stop_prep_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_clk_stop_ok_o <= 1'b0;
    end else begin
      card_clk_stop_ok_o <= clk_stop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = cbf_pkg::RD_ZERO;
    if (rd_i) begin
      case (addr_i)
        // write-only and reserved force bits all read back zero
        cbf_pkg::OFS_FORCE: rdata_nxt = cbf_pkg::RST_FORCE;
        cbf_pkg::OFS_CTRL: rdata_nxt = {24'h00_0000, ctrl_r};
        default: rdata_nxt = cbf_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= cbf_pkg::RD_ZERO;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= rdata_nxt;
      rvalid_o <= rd_i;
    end
  end

endmodule

// ---- verification/cbf_socket_regs_sva.sv ----
/*
  cbf_socket_regs_sva: port-level checks of the socket force/control block.
  assumes: one clock, synchronous active-high reset, bound to every instance.
*/
module cbf_socket_regs_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] wdata_i,
  input wire logic interrog_done_i,
  input wire logic socket_idle_i,
  input wire logic pci_clk_stop_prep_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic interrogate_o,
  input wire logic state_force_wr_o,
  input wire cbf_pkg::cbf_state_force_t state_force_o,
  input wire logic event_force_wr_o,
  input wire cbf_pkg::cbf_event_force_t event_force_o,
  input wire logic power_ctl_en_o,
  input wire logic [2:0] vcc_apply_o,
  input wire logic card_clk_stop_ok_o,
  input wire logic [2:0] socket_cap_o
);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence fwr_s;
    wr_i && addr_i == 8'h0c;
  endsequence
  // retest in the same write re-enables, so only pure forcing writes count
  sequence volt_s;
    wr_i && addr_i == 8'h0c && (|wdata_i[13:10]) && !wdata_i[14] && !interrog_done_i;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  rd_ans_a: assert property (rd_i |=> rvalid_o) else $error("read not answered");
  force_rd_a: assert property (rd_i && addr_i == 8'h0c |=> rdata_o == 32'h0) else $error("force read nonzero");
  rsvd_rd_a: assert property (rvalid_o |-> rdata_o[31:8] == 24'h0 && !rdata_o[3]) else $error("reserved bits set");
  retest_a: assert property (fwr_s |=> interrogate_o == $past(wdata_i[14])) else $error("retest pulse wrong");
  state_copy_a: assert property (fwr_s |=> state_force_wr_o && state_force_o == {$past(wdata_i[13:7]),
    $past(wdata_i[5:4])}) else $error("state force wrong");
  event_copy_a: assert property (fwr_s |=> event_force_wr_o && event_force_o == $past(wdata_i[3:0]))
    else $error("event force wrong");
  pwr_off_a: assert property (volt_s |-> ##2 !power_ctl_en_o) else $error("power not disabled");
  pwr_on_a: assert property (interrog_done_i |-> ##2 power_ctl_en_o) else $error("power not enabled");
  stop_idle_a: assert property (card_clk_stop_ok_o |-> $past(socket_idle_i)) else $error("stop while busy");
  stop_prep_a: assert property (socket_idle_i && pci_clk_stop_prep_i |=> card_clk_stop_ok_o)
    else $error("stop refused");
  supply_a: assert property (vcc_apply_o != 3'h0 |-> vcc_apply_o inside {3'h2, 3'h3}) else $error("bad vcc");
  cap_a: assert property (!$past(rst_i) |-> socket_cap_o == 3'h3) else $error("socket capability wrong");
endmodule

bind cbf_socket_regs cbf_socket_regs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .wdata_i(wdata_i), .interrog_done_i(interrog_done_i), .socket_idle_i(socket_idle_i),
  .pci_clk_stop_prep_i(pci_clk_stop_prep_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .interrogate_o(interrogate_o),
  .state_force_wr_o(state_force_wr_o), .state_force_o(state_force_o), .event_force_wr_o(event_force_wr_o),
  .event_force_o(event_force_o), .power_ctl_en_o(power_ctl_en_o), .vcc_apply_o(vcc_apply_o),
  .card_clk_stop_ok_o(card_clk_stop_ok_o), .socket_cap_o(socket_cap_o));

// ---- verification/cbf_interrog_model.sv ----
/*
  cbf_interrog_model: card interrogation sequencer beside the register block.
  assumes: start is a one-cycle pulse; answer after delay_i+1 cycles.
*/
module cbf_interrog_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] delay_i,
  input wire cbf_pkg::cbf_volt_t volt_i,
  output logic done_o,
  output cbf_pkg::cbf_volt_t volt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_r <= 5'h0;
    else if (start_i) cnt_r <= {1'b0, delay_i} + 5'h1;
    else if (cnt_r != 5'h0) cnt_r <= cnt_r - 5'h1;
  end
  assign done_o = (cnt_r == 5'h1);
  // result only valid with done; stale data would hide a late sample
  assign volt_o = done_o ? volt_i : ~volt_i;
endmodule

// ---- verification/cbf_socket_regs_tb_top.sv ----
/*
  cbf_socket_regs_tb_top: self-checking bench for the socket register block.
  assumes: design inputs change 1 ns after the rising edge.
*/
module cbf_socket_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, wr_i, rd_i, idle, prep, done, ien, stop_ok, inv, srd, swr, ewr, efw;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata, d, seed;
  logic [3:0] dly;
  logic [2:0] vcc, vpp, cap;
  logic [7:0] tab [5];
  cbf_pkg::cbf_volt_t vin, vout;
  cbf_pkg::cbf_state_force_t sf;
  cbf_pkg::cbf_event_force_t ef;
  int errors, checked, n;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  cbf_socket_regs dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .interrog_done_i(done), .interrog_volt_i(vout), .socket_idle_i(idle), .pci_clk_stop_prep_i(prep),
    .rdata_o(rdata), .rvalid_o(srd), .interrogate_o(swr), .state_force_wr_o(ewr), .state_force_o(sf),
    .event_force_wr_o(efw), .event_force_o(ef), .power_ctl_en_o(ien), .vcc_apply_o(vcc), .vpp_apply_o(vpp),
    .card_clk_stop_ok_o(stop_ok), .invalid_power_req_o(inv), .socket_cap_o(cap));
  cbf_interrog_model u_seq (.clk_i(clk_i), .rst_i(rst_i), .start_i(swr), .delay_i(dly), .volt_i(vin),
    .done_o(done), .volt_o(vout));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [2:0] exp_vcc(input logic [7:0] c);
    return (c[6:4] == 3'h2 || c[6:4] == 3'h3) ? c[6:4] : 3'h0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    step();
    wr_i = 1'b1;
    addr_i = a;
    wdata_i = v;
    step();
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    step();
    rd_i = 1'b1;
    addr_i = a;
    step();
    rd_i = 1'b0;
    chk({31'h0, srd}, 32'h1, "rvalid");
    chk(rdata, e, nm);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #50000;
    errors++;
    end_of_test();
  end
  initial begin
    seed = 32'h52;
    tab = '{8'h30, 8'h23, 8'h10, 8'h40, 8'h03};
    {rst_i, wr_i, rd_i, idle, prep, addr_i, wdata_i, dly, vin} = {1'b1, 48'h0, 4'h3};
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rd(8'h0c, 32'h0, "force");
    rd(8'h10, 32'h0, "ctrl");
    chk({31'h0, ien}, 32'h1, "pwr_en");
    chk({29'h0, cap}, 32'h3, "cap");
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      d = (i < 2) ? {32{i[0]}} : lfsr();
      wr(8'h10, d);
      rd(8'h10, d & 32'hf7, "ctrl");
    end
    wr(8'h14, 32'hff);
    rd(8'h14, 32'h0, "unmapped");
    rd(8'h10, d & 32'hf7, "ctrl");
    $display("control test done");
    for (int i = 0; i < 15; i++) begin
      d = 32'h1 << i;
      wr(8'h0c, d);
      chk({23'h0, sf}, {23'h0, d[13:7], d[5:4]}, "state");
      chk({28'h0, ef}, {28'h0, d[3:0]}, "event");
      chk({29'h0, swr, ewr, efw}, {29'h0, d[14], 2'h3}, "retest");
      step();
      if (i > 9 && i < 14) chk({31'h0, ien}, 32'h0, "pwr_off");
      rd(8'h0c, 32'h0, "force");
    end
    dly = 4'h9;
    wr(8'h0c, 32'h4c00);
    step();
    chk({31'h0, ien}, 32'h0, "pwr_off");
    n = 0;
    while (n < 40 && ien !== 1'b1) begin
      step();
      n++;
    end
    chk(n, dly + 32'h2, "retest_wait");
    chk({31'h0, ien}, 32'h1, "pwr_on");
    $display("force test done");
    foreach (tab[k]) begin
      wr(8'h10, {24'h0, tab[k]});
      step();
      chk({26'h0, vcc, vpp}, {26'h0, exp_vcc(tab[k]), (exp_vcc(tab[k]) != 3'h0) ? tab[k][2:0] : 3'h0}, "apply");
      step();
      chk({31'h0, inv}, {31'h0, tab[k] != 8'h00 && exp_vcc(tab[k]) == 3'h0}, "invalid");
    end
    $display("supply test done");
    for (int i = 0; i < 8; i++) begin
      d = lfsr();
      wr(8'h10, {24'h0, d[0], 7'h0});
      idle = d[1];
      prep = d[2];
      step();
      chk({31'h0, stop_ok}, {31'h0, d[1] & (d[0] | d[2])}, "clk_stop");
    end
    $display("clock test done");
    end_of_test();
  end
endmodule
